/* design/fgu_defs.svh */
`ifndef FGU_DEFS_SVH
`define FGU_DEFS_SVH

// ==========================================================
// command opcodes
`define FGU_OP_WREN          8'h06
`define FGU_OP_GLOBAL_LOCK   8'h7e
`define FGU_OP_GLOBAL_UNLOCK 8'h98
`define FGU_OP_RESET_ARM     8'h66
`define FGU_OP_RESET         8'h99
`define FGU_OP_BITS          4'h8

// ==========================================================
// timing
`define FGU_PCLK_MHZ 50
`define FGU_TRST_US  30
`define FGU_RST_CYC  (`FGU_TRST_US * `FGU_PCLK_MHZ)

// ==========================================================
// register offsets
`define FGU_ADDR_CTRL      8'h00
`define FGU_ADDR_STATUS    8'h04
`define FGU_ADDR_LOCK_SEL  8'h08
`define FGU_ADDR_LOCK_DATA 8'h0c

// ==========================================================
// field positions
`define FGU_CTRL_WPS      0
`define FGU_CTRL_SUS      1
`define FGU_CTRL_OPACT    2
`define FGU_CTRL_WRAP_LO  4
`define FGU_CTRL_WRAP_HI  6
`define FGU_CTRL_PARAM_LO 8
`define FGU_CTRL_PARAM_HI 15
`define FGU_STAT_WEL      0
`define FGU_STAT_ARM      1
`define FGU_STAT_BUSY     2
`define FGU_LDAT_BIT      0
`define FGU_LDAT_ALL      1
`define FGU_LDAT_NONE     2

// ==========================================================
// reset values
`define FGU_PARAM_RST 8'h00
`define FGU_WRAP_RST  3'h0

`endif

/* design/fgu_pkg.sv */
package fgu_pkg;
  typedef enum logic [0:0] {FGU_READY, FGU_RESETTING} fgu_state_t;
  typedef logic [7:0] fgu_opcode_t;
endpackage

/* design/fgu_lock_mem.sv */
`timescale 1ns/10ps
module fgu_lock_mem #(
  parameter int NBLK = 64,
  parameter int IW   = 6
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          set_all,
  input  wire logic          clr_all,
  input  wire logic [IW-1:0] sel,
  output logic               rd_bit_r,
  output logic               all_set_r,
  output logic               none_set_r
);
  logic [NBLK-1:0] bits_r;

  // ==========================================================
  // protection bits, volatile, all set out of reset
  genvar g;
  generate
    for (g = 0; g < NBLK; g++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          bits_r[g] <= 1'b1;
        end else if (set_all) begin
          bits_r[g] <= 1'b1;
        end else if (clr_all) begin
          bits_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // registered read side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_bit_r   <= 1'b1;
      all_set_r  <= 1'b1;
      none_set_r <= 1'b0;
    end else begin
      rd_bit_r   <= bits_r[sel];
      all_set_r  <= &bits_r;
      none_set_r <= ~|bits_r;
    end
  end
endmodule // fgu_lock_mem

/* design/fgu_top.sv */
`timescale 1ns/10ps
`include "fgu_defs.svh"
module fgu_top #(
  parameter int NBLK    = 64,
  parameter int IW      = 6,
  parameter int RST_CYC = `FGU_RST_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        di,
  output logic             busy_out,
  output logic             write_enable_latch,
  output logic             blk_protected
);
  localparam int CW = $clog2(RST_CYC + 1);

  // ==========================================================
  // link side, on the serial clock
  logic [3:0] bit_cnt_r;
  logic [6:0] shift_r;
  logic [7:0] op_hold_r;
  logic       len_ok_r;
  logic       over_r;
  logic       frame_tog_r;

  // chip select high clears the count; no serial edge exists then
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_r <= 4'h0;
    end else if (bit_cnt_r != 4'hf) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // held fields survive deselect so the pclk side can read them
  always_ff @(posedge sclk or negedge presetn) begin
    if (!presetn) begin
      shift_r     <= 7'h00;
      op_hold_r   <= 8'h00;
      len_ok_r    <= 1'b0;
      over_r      <= 1'b0;
      frame_tog_r <= 1'b0;
    end else if (!cs_n) begin
      shift_r <= {shift_r[5:0], di};
      if (bit_cnt_r == 4'h0) begin
        frame_tog_r <= ~frame_tog_r;
        len_ok_r    <= 1'b0;
        over_r      <= 1'b0;
      end
      if (bit_cnt_r == `FGU_OP_BITS - 4'h1) begin
        op_hold_r <= {shift_r, di};
        len_ok_r  <= 1'b1;
      end
      if (bit_cnt_r >= `FGU_OP_BITS) begin
        over_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // crossing into pclk
  logic cs_s1_r, cs_s2_r, cs_d_r;
  logic tog_s1_r, tog_s2_r, tog_seen_r;
  logic frame_end, frame_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_s1_r    <= 1'b1;
      cs_s2_r    <= 1'b1;
      cs_d_r     <= 1'b1;
      tog_s1_r   <= 1'b0;
      tog_s2_r   <= 1'b0;
      tog_seen_r <= 1'b0;
    end else begin
      cs_s1_r  <= cs_n;
      cs_s2_r  <= cs_s1_r;
      cs_d_r   <= cs_s2_r;
      tog_s1_r <= frame_tog_r;
      tog_s2_r <= tog_s1_r;
      if (frame_end) begin
        tog_seen_r <= tog_s2_r;
      end
    end
  end

  // held fields are quiet here: the link is deselected and idle
  assign frame_end = cs_s2_r & ~cs_d_r & (tog_s2_r != tog_seen_r);
  assign frame_ok  = frame_end & len_ok_r & ~over_r;

  // ==========================================================
  // command decode
  fgu_pkg::fgu_state_t  state_r;
  fgu_pkg::fgu_opcode_t op;
  logic [CW-1:0]        rst_cnt_r;
  logic arm_r, cmd_live;
  logic do_wren, do_unlock, do_lock, do_arm, do_reset;

  assign op        = op_hold_r;
  assign cmd_live  = frame_ok & (state_r == fgu_pkg::FGU_READY);
  assign do_wren   = cmd_live & (op == `FGU_OP_WREN);
  assign do_unlock = cmd_live & (op == `FGU_OP_GLOBAL_UNLOCK)
                     & write_enable_latch;
  assign do_lock   = cmd_live & (op == `FGU_OP_GLOBAL_LOCK)
                     & write_enable_latch;
  assign do_arm    = cmd_live & (op == `FGU_OP_RESET_ARM);
  assign do_reset  = cmd_live & (op == `FGU_OP_RESET) & arm_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_r <= 1'b0;
    end else if (do_arm) begin
      arm_r <= 1'b1;
    end else if (cmd_live) begin
      arm_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_enable_latch <= 1'b0;
    end else if (do_reset) begin
      write_enable_latch <= 1'b0;
    end else if (do_wren) begin
      write_enable_latch <= 1'b1;
    end else if (do_unlock || do_lock) begin
      write_enable_latch <= 1'b0;
    end
  end

  // ==========================================================
  // recovery after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= fgu_pkg::FGU_READY;
      rst_cnt_r <= '0;
    end else begin
      case (state_r)
        fgu_pkg::FGU_READY: begin
          if (do_reset) begin
            state_r   <= fgu_pkg::FGU_RESETTING;
            rst_cnt_r <= CW'(RST_CYC - 1);
          end
        end
        fgu_pkg::FGU_RESETTING: begin
          if (rst_cnt_r == '0) begin
            state_r <= fgu_pkg::FGU_READY;
          end else begin
            rst_cnt_r <= rst_cnt_r - CW'(1);
          end
        end
        default: state_r <= fgu_pkg::FGU_READY;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= do_reset | ((state_r == fgu_pkg::FGU_RESETTING)
                              & (rst_cnt_r != '0));
    end
  end

  // ==========================================================
  // apb slave
  logic          wps_r, sus_r, opact_r;
  logic [7:0]    param_r;
  logic [2:0]    wrap_r;
  logic [IW-1:0] lock_sel_r;
  logic          lock_bit, lock_all, lock_none;
  logic          setup, wr_en, mapped;
  logic [31:0]   rd_mux;

  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pready & pwrite & mapped;
  assign mapped = (paddr == `FGU_ADDR_CTRL) | (paddr == `FGU_ADDR_STATUS)
                | (paddr == `FGU_ADDR_LOCK_SEL)
                | (paddr == `FGU_ADDR_LOCK_DATA);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `FGU_ADDR_CTRL: begin
        rd_mux[`FGU_CTRL_WPS]   = wps_r;
        rd_mux[`FGU_CTRL_SUS]   = sus_r;
        rd_mux[`FGU_CTRL_OPACT] = opact_r;
        rd_mux[`FGU_CTRL_WRAP_HI:`FGU_CTRL_WRAP_LO]   = wrap_r;
        rd_mux[`FGU_CTRL_PARAM_HI:`FGU_CTRL_PARAM_LO] = param_r;
      end
      `FGU_ADDR_STATUS: begin
        rd_mux[`FGU_STAT_WEL]  = write_enable_latch;
        rd_mux[`FGU_STAT_ARM]  = arm_r;
        rd_mux[`FGU_STAT_BUSY] = busy_out;
      end
      `FGU_ADDR_LOCK_SEL:  rd_mux[IW-1:0] = lock_sel_r;
      `FGU_ADDR_LOCK_DATA: begin
        rd_mux[`FGU_LDAT_BIT]  = lock_bit;
        rd_mux[`FGU_LDAT_ALL]  = lock_all;
        rd_mux[`FGU_LDAT_NONE] = lock_none;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // one access cycle, no waits; read data captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // scheme select is not volatile, so a reset keeps it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wps_r      <= 1'b0;
      lock_sel_r <= '0;
    end else if (wr_en) begin
      if (paddr == `FGU_ADDR_CTRL) begin
        wps_r <= pwdata[`FGU_CTRL_WPS];
      end
      if (paddr == `FGU_ADDR_LOCK_SEL) begin
        lock_sel_r <= pwdata[IW-1:0];
      end
    end
  end

  // reset wins over a same-cycle software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sus_r   <= 1'b0;
      opact_r <= 1'b0;
      param_r <= `FGU_PARAM_RST;
      wrap_r  <= `FGU_WRAP_RST;
    end else if (do_reset) begin
      sus_r   <= 1'b0;
      opact_r <= 1'b0;
      param_r <= `FGU_PARAM_RST;
      wrap_r  <= `FGU_WRAP_RST;
    end else if (wr_en && paddr == `FGU_ADDR_CTRL) begin
      sus_r   <= pwdata[`FGU_CTRL_SUS];
      opact_r <= pwdata[`FGU_CTRL_OPACT];
      param_r <= pwdata[`FGU_CTRL_PARAM_HI:`FGU_CTRL_PARAM_LO];
      wrap_r  <= pwdata[`FGU_CTRL_WRAP_HI:`FGU_CTRL_WRAP_LO];
    end
  end

  // ==========================================================
  // protection bits
  fgu_lock_mem #(
    .NBLK (NBLK),
    .IW   (IW)
  ) u_lock (
    .clk        (pclk),
    .rst_n      (presetn),
    .set_all    (do_lock | do_reset),
    .clr_all    (do_unlock),
    .sel        (lock_sel_r),
    .rd_bit_r   (lock_bit),
    .all_set_r  (lock_all),
    .none_set_r (lock_none)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_protected <= 1'b0;
    end else begin
      blk_protected <= lock_bit & wps_r;
    end
  end

  // ==========================================================
  // checks
  logic [CW:0] busy_len_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_len_r <= '0;
    end else if (busy_out) begin
      busy_len_r <= busy_len_r + (CW+1)'(1);
    end else begin
      busy_len_r <= '0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_reset_accept;
    do_reset;
  endsequence

  sequence s_lone_reset;
    cmd_live && (op == `FGU_OP_RESET) && !arm_r;
  endsequence

  a_unlock_clears_all: assert property (
    do_unlock |-> ##2 lock_none)
    else $error("global unlock left protection bits set");
  a_unlock_needs_wel: assert property (
    (cmd_live && op == `FGU_OP_GLOBAL_UNLOCK && !write_enable_latch
     && !lock_none) |-> ##2 !lock_none)
    else $error("unlock acted without write enable");
  a_reset_aborts_op: assert property (
    s_reset_accept |=> !opact_r && state_r == fgu_pkg::FGU_RESETTING)
    else $error("reset did not abort operation");
  a_reset_drops_volatile: assert property (
    s_reset_accept |=> !write_enable_latch && !sus_r
      && param_r == `FGU_PARAM_RST && wrap_r == `FGU_WRAP_RST)
    else $error("reset kept a volatile setting");
  a_reset_needs_pair: assert property (
    s_lone_reset |=> state_r == fgu_pkg::FGU_READY && !busy_out)
    else $error("reset accepted without arming");
  a_arm_dropped: assert property (
    (cmd_live && op != `FGU_OP_RESET && op != `FGU_OP_RESET_ARM)
    |=> !arm_r)
    else $error("arming survived another command");
  a_reset_busy_hold: assert property (
    s_reset_accept |=> busy_out [*8])
    else $error("busy not held after reset");
  a_reset_busy_len: assert property (
    $fell(busy_out) |-> busy_len_r == (CW+1)'(RST_CYC))
    else $error("reset period has wrong length");
  a_busy_deaf: assert property (
    (frame_ok && state_r == fgu_pkg::FGU_RESETTING)
    |=> $stable(arm_r) && $stable(write_enable_latch))
    else $error("command taken during reset period");
  a_reset_locks_all: assert property (
    s_reset_accept |-> ##2 lock_all)
    else $error("reset did not set protection bits");
  a_scheme_gate: assert property (
    !wps_r |=> !blk_protected)
    else $error("block protected while scheme select is off");
  a_global_lock_sets: assert property (
    do_lock |-> ##2 lock_all)
    else $error("global lock left bits clear");
  a_lone_reset_inert: assert property (
    s_lone_reset |=> $stable(write_enable_latch) && $stable(param_r))
    else $error("unarmed reset changed state");
  a_bad_frame_inert: assert property (
    (frame_end && !(len_ok_r && !over_r))
    |=> $stable(arm_r) && $stable(write_enable_latch))
    else $error("malformed frame was acted on");
endmodule // fgu_top

/* tb/fgu_host_model.sv */
`timescale 1ns/10ps
// ==========================================================
// host controller on the serial link
module fgu_host_model (
  output logic sclk,
  output logic cs_n,
  output logic di
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    di   = 1'b0;
  end

  // clock only runs inside a frame; di not held once released
  task automatic send(input logic [7:0] op, input int nbits);
    int i;
    #3;
    cs_n = 1'b0;
    for (i = 0; i < nbits; i++) begin
      di = op[7 - (i % 8)];
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
    end
    #6 cs_n = 1'b1;
    di = ~di;
  endtask
endmodule // fgu_host_model

/* tb/testbench.sv */
`timescale 1ns/10ps
`include "fgu_defs.svh"
// ==========================================================
// bench top
module testbench;
  localparam int RST_CYC = 60;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sclk;
  logic        cs_n;
  logic        di;
  logic        busy_out;
  logic        write_enable_latch;
  logic        blk_protected;
  logic [15:0] lfsr;
  logic [31:0] rd;
  logic [31:0] ctrl_v;
  logic        rerr;
  int          err_count;
  int          comparisons;
  int          cycles;
  int          n;

  fgu_top #(.RST_CYC(RST_CYC)) fgu_top_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
    .cs_n(cs_n), .di(di), .busy_out(busy_out),
    .write_enable_latch(write_enable_latch),
    .blk_protected(blk_protected)
  );
  fgu_host_model fgu_host_model_i (.sclk(sclk), .cs_n(cs_n), .di(di));

  always #10 pclk = ~pclk;

  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // scheme select survives reset, the rest is volatile
  function automatic logic [31:0] ctrl_after_rst(input logic [31:0] c);
    return c & 32'h0000_0001;
  endfunction
  function automatic logic [31:0] lock_exp(input logic all_set);
    return all_set ? 32'h0000_0003 : 32'h0000_0004;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t ns: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t ns: no bus answer", $time);
    end
    rd = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  // cs_n stays high well over four cycles before the next frame
  task automatic frame(input logic [7:0] op, input int nbits);
    fgu_host_model_i.send(op, nbits);
    repeat (6) @(posedge pclk);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("mismatch at %0t ns: run too long", $time);
      wrap_up();
    end
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    lfsr = 16'hb764;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // power-up write delay shortened: host duty only
    rd_chk(`FGU_ADDR_STATUS, 32'h0, "status at reset");
    apb(1'b1, `FGU_ADDR_LOCK_SEL, {26'h0, lfsr[5:0]});
    rd_chk(`FGU_ADDR_LOCK_DATA, lock_exp(1'b1), "lock default");
    chk({31'h0, blk_protected}, 32'h0, "scheme off");
    apb(1'b1, `FGU_ADDR_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, blk_protected}, 32'h1, "scheme on");
    $display("test defaults done");
    frame(`FGU_OP_GLOBAL_UNLOCK, 8);
    rd_chk(`FGU_ADDR_LOCK_DATA, lock_exp(1'b1), "unlock no latch");
    frame(`FGU_OP_WREN, 9);
    chk({31'h0, write_enable_latch}, 32'h0, "long frame");
    frame(`FGU_OP_WREN, 7);
    chk({31'h0, write_enable_latch}, 32'h0, "short frame");
    frame(`FGU_OP_WREN, 8);
    chk({31'h0, write_enable_latch}, 32'h1, "latch set");
    frame(`FGU_OP_GLOBAL_UNLOCK, 8);
    rd_chk(`FGU_ADDR_LOCK_DATA, lock_exp(1'b0), "unlock");
    chk({31'h0, blk_protected}, 32'h0, "unprotected");
    frame(`FGU_OP_GLOBAL_LOCK, 8);
    rd_chk(`FGU_ADDR_LOCK_DATA, lock_exp(1'b0), "lock no latch");
    frame(`FGU_OP_WREN, 8);
    frame(`FGU_OP_GLOBAL_LOCK, 8);
    rd_chk(`FGU_ADDR_LOCK_DATA, lock_exp(1'b1), "lock all");
    $display("test lock and unlock done");
    // host has checked busy and suspend before each pair
    repeat (3) begin
      lfsr = next_rand(lfsr);
      ctrl_v = {16'h0, lfsr[15:8], 1'b0, lfsr[6:4], 1'b0, lfsr[2:1], 1'b1};
      apb(1'b1, `FGU_ADDR_CTRL, ctrl_v);
      frame(`FGU_OP_WREN, 8);
      frame(`FGU_OP_GLOBAL_UNLOCK, 8);
      frame(`FGU_OP_RESET_ARM, 8);
      frame(`FGU_OP_WREN, 8);
      frame(`FGU_OP_RESET, 8);
      rd_chk(`FGU_ADDR_CTRL, ctrl_v, "arm dropped");
      frame(`FGU_OP_RESET, 8);
      rd_chk(`FGU_ADDR_STATUS, 32'h1, "unarmed reset");
      frame(`FGU_OP_RESET_ARM, 8);
      rd_chk(`FGU_ADDR_STATUS, 32'h3, "armed");
      frame(`FGU_OP_RESET, 8);
      chk({31'h0, busy_out}, 32'h1, "busy after reset");
      rd_chk(`FGU_ADDR_CTRL, ctrl_after_rst(ctrl_v), "volatile");
      chk({31'h0, write_enable_latch}, 32'h0, "latch dropped");
      frame(`FGU_OP_WREN, 8);
      chk({31'h0, write_enable_latch}, 32'h0, "busy ignores");
      n = 0;
      while (busy_out !== 1'b0 && n < 200) begin
        @(posedge pclk);
        n++;
      end
      chk({31'h0, busy_out}, 32'h0, "busy ends");
      rd_chk(`FGU_ADDR_LOCK_DATA, lock_exp(1'b1), "lock reset");
      rd_chk(`FGU_ADDR_STATUS, 32'h0, "status reset");
      frame(`FGU_OP_WREN, 8);
      chk({31'h0, write_enable_latch}, 32'h1, "ready again");
    end
    $display("test software reset done");
    apb(1'b1, 8'h10, {16'h0, lfsr});
    chk({31'h0, rerr}, 32'h1, "unmapped write");
    rd_chk(8'h10, 32'h0, "unmapped read");
    chk({31'h0, rerr}, 32'h1, "unmapped error");
    $display("test unmapped done");
    wrap_up();
  end
endmodule // testbench
